/* File: rtl/dsw_pkg.sv */
// Package of the serial write port: word layout and link timing constants.
// Assumes both ends refer to names here as dsw_pkg::name; the bench uses none of them.
package dsw_pkg;
    localparam int WORD_BITS     = 16;
    localparam int BYTE_BITS     = 8;
    localparam int CTRL_MSB      = 15;
    localparam int CTRL_LSB      = 12;
    localparam int ADDR_MSB      = 11;
    localparam int ADDR_LSB      = 8;
    localparam int DATA_MSB      = 7;
    localparam int DATA_LSB      = 0;
    localparam int CTRL_BITS     = 4;
    localparam int ADDR_BITS     = 4;
    localparam int DATA_BITS     = 8;
    // Host divider: half period of serial clock in ref_clk cycles
    localparam int SCLK_HALF_DIV = 16;
    // Idle gap between bytes of a split word, in ref_clk cycles
    localparam int BYTE_GAP_CYC  = 32;
    localparam logic [15:0] WORD_RST = 16'h0000;
endpackage

/* File: rtl/dsw_link_if.sv */
// Interface joining the host end and the device end of the serial link.
// Assumes the host drives all three wires; the device only listens.
`timescale 1ns/10ps
interface dsw_link_if;
    logic sclk;
    logic frame_select_n;
    logic serial_data_in;
    modport host_mp (
        output sclk,
        output frame_select_n,
        output serial_data_in
    );
    modport dev_mp (
        input  sclk,
        input  frame_select_n,
        input  serial_data_in
    );
endinterface

/* File: rtl/dsw_host.sv */
// Host end: turns a 16-bit user word into a framed serial transfer.
// Assumes ref_clk is 200 MHz; derives the link clock by a divider.
// Assumes the requester holds its fields steady while req_valid is high.
// Each bit spends HALF_DIV cycles high then HALF_DIV low; data moves on
// the rise, so it has settled a full half period before the device's
// sampling fall. Only an active-low frame is made; a host wired to an
// inverted frame input needs an inverter outside this block.
`timescale 1ns/10ps
module dsw_host #(
    parameter int HALF_DIV = dsw_pkg::SCLK_HALF_DIV,
    parameter int GAP_CYC  = dsw_pkg::BYTE_GAP_CYC
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // User request
    input  wire logic             req_valid,
    input  wire logic             req_byte_mode,
    input  wire logic [3:0]       req_ctrl,
    input  wire logic [3:0]       req_addr,
    input  wire logic [7:0]       req_data,
    output logic                  req_ready,
    // Link
    dsw_link_if.host_mp           link
);
    // Transmitter states; codes written out
    typedef enum logic [2:0] {
        DSW_IDLE  = 3'b000,
        DSW_SETUP = 3'b001,
        DSW_HIGH  = 3'b010,
        DSW_LOW   = 3'b011,
        DSW_GAP   = 3'b100,
        DSW_DONE  = 3'b101
    } dsw_host_st_t;

    // Counter end points, cut to the counter widths once here so the
    // comparisons below meet operands of equal size
    localparam logic [7:0] HALF_END  = 8'(HALF_DIV - 1);
    localparam logic [7:0] GAP_END   = 8'(GAP_CYC - 1);
    localparam logic [4:0] LAST_BIT  = 5'(dsw_pkg::WORD_BITS - 1);
    localparam logic [4:0] BYTE_LAST = 5'(dsw_pkg::BYTE_BITS - 1);

    // Word image in send order: the first bit to leave sits at the top,
    // whatever order a host's own shifter would use
    function automatic logic [15:0] pack_word(
        input logic [3:0] ctrl,
        input logic [3:0] addr,
        input logic [7:0] data
    );
        pack_word = {ctrl, addr, data};
    endfunction

    // Transmitter state
    dsw_host_st_t state_q, state_d;
    logic [15:0]  shift_q, shift_d;
    logic [4:0]   bits_q, bits_d;
    logic [7:0]   cnt_q, cnt_d;
    logic         byte_q, byte_d;
    logic         sclk_q, sclk_d;
    logic         fsn_q, fsn_d;
    logic         sdo_q, sdo_d;
    logic         rdy_q, rdy_d;

    // Next-state logic of the transmitter
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        bits_d  = bits_q;
        cnt_d   = cnt_q;
        byte_d  = byte_q;
        sclk_d  = sclk_q;
        fsn_d   = fsn_q;
        sdo_d   = sdo_q;
        rdy_d   = rdy_q;
        case (state_q)
            DSW_IDLE: begin
                // Clock and frame rest high; ready shows a word can be taken
                sclk_d = 1'b1;
                fsn_d  = 1'b1;
                rdy_d  = 1'b1;
                if (req_valid && rdy_q) begin
                    // Fields packed top down
                    shift_d = pack_word(req_ctrl, req_addr, req_data);
                    byte_d  = req_byte_mode;
                    bits_d  = 5'd0;
                    cnt_d   = 8'h00;
                    rdy_d   = 1'b0;
                    // Frame falls with the first bit already on the line
                    fsn_d   = 1'b0;
                    sdo_d   = req_ctrl[3];
                    state_d = DSW_SETUP;
                end
            end

            DSW_SETUP: begin
                // Frame settles a full period, this half plus the high half, before the first fall
                if (cnt_q == HALF_END) begin
                    cnt_d   = 8'h00;
                    state_d = DSW_HIGH;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end

            DSW_HIGH: begin
                // High half of a bit; the fall at its end is the sample point
                if (cnt_q == HALF_END) begin
                    cnt_d   = 8'h00;
                    sclk_d  = 1'b0;
                    state_d = DSW_LOW;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end

            DSW_LOW: begin
                // Low half of a bit; data must not move until the rise
                if (cnt_q == HALF_END) begin
                    cnt_d  = 8'h00;
                    sclk_d = 1'b1;
                    // Next bit changes on the rising edge
                    shift_d = {shift_q[14:0], 1'b0};
                    sdo_d   = shift_q[14];
                    bits_d  = bits_q + 5'd1;
                    // A word ends after sixteen bits, a byte pause after eight
                    if (bits_q == LAST_BIT) begin
                        state_d = DSW_DONE;
                    end else if (byte_q && bits_q == BYTE_LAST) begin
                        state_d = DSW_GAP;
                    end else begin
                        state_d = DSW_HIGH;
                    end
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end

            DSW_GAP: begin
                // Clock held high, frame held low
                // The gap length is ours; the device only needs no fall
                if (cnt_q == GAP_END) begin
                    cnt_d   = 8'h00;
                    state_d = DSW_HIGH;
                end else begin
                    cnt_d = cnt_q + 8'h01;
                end
            end

            DSW_DONE: begin
                // Frame rises only after the sixteenth bit
                // Ready comes back from idle, so the frame rests high for
                // at least two cycles before the next word
                fsn_d   = 1'b1;
                state_d = DSW_IDLE;
            end

            default: begin
                // Unused codes fall back to idle; clock and frame keep their levels until idle rests them
                state_d = DSW_IDLE;
            end
        endcase
    end

    // State registers; reset leaves the link at rest, clock and frame high,
    // and keeps ready low until the first cycle out of reset
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= DSW_IDLE;
            shift_q <= dsw_pkg::WORD_RST;
            bits_q  <= 5'h00;
            cnt_q   <= 8'h00;
            byte_q  <= 1'b0;
            sclk_q  <= 1'b1;
            fsn_q   <= 1'b1;
            sdo_q   <= 1'b0;
            rdy_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            bits_q  <= bits_d;
            cnt_q   <= cnt_d;
            byte_q  <= byte_d;
            sclk_q  <= sclk_d;
            fsn_q   <= fsn_d;
            sdo_q   <= sdo_d;
            rdy_q   <= rdy_d;
        end
    end

    // Outputs come straight from flip-flops, so the link wires never
    // glitch while the next-state logic settles
    assign link.sclk           = sclk_q;
    assign link.frame_select_n = fsn_q;
    assign link.serial_data_in = sdo_q;
    assign req_ready           = rdy_q;
endmodule

/* File: rtl/dsw_device.sv */
// Device end: shifts framed bits on the falling serial clock edge and
// hands complete words to the ref_clk domain by a toggle handshake.
// Assumes the host idles the clock high and frames each word.
`timescale 1ns/10ps
module dsw_device (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // Link
    dsw_link_if.dev_mp       link,
    // Received word, ref_clk domain
    output logic             word_valid,
    output logic [3:0]       word_ctrl,
    output logic [3:0]       word_addr,
    output logic [7:0]       word_data
);
    logic [15:0] sh_q, sh_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [15:0] hold_q, hold_d;
    logic        tog_q, tog_d;

    // Link side: count and shift while framed; the frame's rise clears the
    // count asynchronously so a partial word is dropped
    always_comb begin
        sh_d   = {sh_q[14:0], link.serial_data_in};
        cnt_d  = cnt_q + 5'd1;
        hold_d = hold_q;
        tog_d  = tog_q;
        if (cnt_q == 5'(dsw_pkg::WORD_BITS - 1)) begin
            // Sixteenth bit captured while framed
            hold_d = {sh_q[14:0], link.serial_data_in};
            tog_d  = ~tog_q;
            cnt_d  = 5'd0;
        end
    end

    always_ff @(negedge link.sclk or posedge link.frame_select_n) begin
        if (link.frame_select_n) begin
            cnt_q <= 5'd0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Data flops need no reset; they are qualified by the toggle
    always_ff @(negedge link.sclk) begin
        if (!link.frame_select_n) begin
            sh_q   <= sh_d;
            hold_q <= hold_d;
        end
    end

    // The toggle needs a known start or its inverse stays unknown forever.
    // The link clock stops between frames, so nrst acts on it directly;
    // the host holds the clock high through reset, so no edge races it.
    always_ff @(negedge link.sclk or negedge nrst) begin
        if (!nrst) begin
            tog_q <= 1'b0;
        end else if (!link.frame_select_n) begin
            tog_q <= tog_d;
        end
    end

    // Crossing into ref_clk: toggle through two flops, then edge detect
    logic sy1_q, sy2_q, sy3_q;
    logic vld_q;
    logic [15:0] word_q;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sy1_q  <= 1'b0;
            sy2_q  <= 1'b0;
            sy3_q  <= 1'b0;
            vld_q  <= 1'b0;
            word_q <= dsw_pkg::WORD_RST;
        end else begin
            sy1_q <= tog_q;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            vld_q <= sy2_q ^ sy3_q;
            // Hold word is stable for many ref_clk cycles after toggle
            if (sy2_q ^ sy3_q) begin
                word_q <= hold_q;
            end
        end
    end

    // Fields split per word layout
    assign word_valid = vld_q;
    assign word_ctrl  = word_q[dsw_pkg::CTRL_MSB:dsw_pkg::CTRL_LSB];
    assign word_addr  = word_q[dsw_pkg::ADDR_MSB:dsw_pkg::ADDR_LSB];
    assign word_data  = word_q[dsw_pkg::DATA_MSB:dsw_pkg::DATA_LSB];
endmodule

/* File: testbench/dsw_link_checker.sv */
// Checker of the link wires between the host end and the device end.
// Assumes the host moves every wire on ref_clk rising edges.
`timescale 1ns/10ps
module dsw_link_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Link
    input wire logic sclk,
    input wire logic frame_select_n,
    input wire logic serial_data_in
);
    localparam int MAX_FRAME = 1000;
    logic       sclk_q;
    logic [4:0] fall_q;
    logic [4:0] fall_d;
    // Falls inside a frame; a high frame clears the count
    always_comb begin
        fall_d = fall_q;
        if (frame_select_n) begin
            fall_d = 5'h00;
        end else if (sclk_q && !sclk) begin
            fall_d = fall_q + 5'h01;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sclk_q <= 1'b1;
            fall_q <= 5'h00;
        end else begin
            sclk_q <= sclk;
            fall_q <= fall_d;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_open;
        $fell(frame_select_n);
    endsequence
    sequence s_close;
        $rose(frame_select_n);
    endsequence
    a_open_clk_high: assert property (s_open |-> sclk)
        else $error("frame opened with clock low");
    a_idle_clk_high: assert property (frame_select_n |-> sclk)
        else $error("clock low outside a frame");
    a_sixteen_falls: assert property (s_close |-> fall_q == 5'h10)
        else $error("frame closed without sixteen bits");
    a_no_extra_fall: assert property ($fell(sclk) |-> fall_q < 5'h10)
        else $error("more than sixteen falls in a frame");
    a_data_held_low: assert property
        (!frame_select_n && !sclk |-> $stable(serial_data_in))
        else $error("data moved while clock low");
    a_frame_bounded: assert property
        (s_open |-> ##[1:MAX_FRAME] s_close)
        else $error("frame never closed");
    a_frame_gap: assert property (s_close |=> frame_select_n)
        else $error("frame reopened at once");
    a_fall_in_frame: assert property
        ($fell(sclk) |-> !$past(frame_select_n))
        else $error("clock fell before frame was low");
endmodule

/* File: testbench/dds_serial_write_port_tb.sv */
// Bench: host end feeds the device end; a second device is driven by hand.
// Assumes shortened host counts; hand link clock period is 160 ns.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    err_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module dds_serial_write_port_tb;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_byte_mode = 1'b0;
    logic [15:0] req_w = 16'h0000;
    logic        req_ready;
    logic        word_valid, word_valid_2;
    logic [3:0]  word_ctrl, word_addr, word_ctrl_2, word_addr_2;
    logic [7:0]  word_data, word_data_2;
    logic [15:0] wire_sh = 16'h0000;
    int          cnt2 = 0;
    int          err_count = 0;
    int          n_checks = 0;
    dsw_link_if  lnk ();
    dsw_link_if  lnk2 ();
    dsw_host #(.HALF_DIV(2), .GAP_CYC(2)) u_dsw_host (.ref_clk(ref_clk),
        .nrst(nrst), .req_valid(req_valid), .req_byte_mode(req_byte_mode),
        .req_ctrl(req_w[15:12]), .req_addr(req_w[11:8]),
        .req_data(req_w[7:0]), .req_ready(req_ready), .link(lnk));
    dsw_device u_dsw_device (.ref_clk(ref_clk), .nrst(nrst), .link(lnk),
        .word_valid(word_valid), .word_ctrl(word_ctrl),
        .word_addr(word_addr), .word_data(word_data));
    dsw_device u_dsw_device_2 (.ref_clk(ref_clk), .nrst(nrst), .link(lnk2),
        .word_valid(word_valid_2), .word_ctrl(word_ctrl_2),
        .word_addr(word_addr_2), .word_data(word_data_2));
    dsw_link_checker u_dsw_link_checker (.ref_clk(ref_clk), .nrst(nrst),
        .sclk(lnk.sclk), .frame_select_n(lnk.frame_select_n),
        .serial_data_in(lnk.serial_data_in));
    initial forever #2.5 ref_clk = ~ref_clk;
    // Wire image taken where the device samples, to judge bit order
    always @(negedge lnk.sclk) begin
        if (!lnk.frame_select_n) wire_sh <= {wire_sh[14:0], lnk.serial_data_in};
    end
    always @(posedge ref_clk) begin
        if (word_valid_2 === 1'b1) cnt2++;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Bounded wait for ready (sel low) or a word (sel high); running out
    // ends the run
    task automatic wait_hi(input logic sel);
        int i;
        for (i = 0; i < 200 && (sel ? word_valid : req_ready) !== 1'b1;
             i++) begin
            @(negedge ref_clk);
        end
        if (i == 200) begin
            err_count++;
            give_verdict();
        end
    endtask
    task automatic send(input logic bm, input logic [15:0] w);
        wait_hi(1'b0);
        req_valid = 1'b1;
        req_byte_mode = bm;
        req_w = w;
        @(negedge ref_clk);
        req_valid = 1'b0;
        `CHK("busy", 1'b0, req_ready)
        wait_hi(1'b1);
        `CHK("fields", w, {word_ctrl, word_addr, word_data})
        `CHK("wire", w, wire_sh)
    endtask
    // Hand-driven host on the second link; n below 16 cuts the frame short
    task automatic bang(input logic [15:0] w, input int n);
        lnk2.frame_select_n = 1'b0;
        for (int b = 15; b > 15 - n; b--) begin
            lnk2.serial_data_in = w[b];
            #40;
            lnk2.sclk = 1'b0;
            #80;
            lnk2.sclk = 1'b1;
            #40;
        end
        lnk2.frame_select_n = 1'b1;
        lnk2.serial_data_in = ~w[16-n];
        #400;
    endtask
    initial begin
        lnk2.sclk = 1'b1;
        lnk2.frame_select_n = 1'b1;
        lnk2.serial_data_in = 1'b0;
        // Reset falls after time zero so the link-side toggle sees an edge
        #1;
        nrst = 1'b0;
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        send(1'b0, 16'hF0A5);
        send(1'b1, 16'h5A0F);
        send(1'b1, 16'hFFFF);
        send(1'b0, 16'h0000);
        $display("test host_to_device done");
        #3;
        bang(16'h3C96, 16);
        `CHK("count2", 1, cnt2)
        `CHK("word2", 16'h3C96, {word_ctrl_2, word_addr_2, word_data_2})
        bang(16'hAAAA, 10);
        `CHK("partial", 1, cnt2)
        bang(16'hC35A, 16);
        `CHK("count2", 2, cnt2)
        `CHK("word2", 16'hC35A, {word_ctrl_2, word_addr_2, word_data_2})
        $display("test partial_frame done");
        give_verdict();
    end
endmodule
